// [hdl/mclr_log_bank.sv]
`timescale 1ns/10ps
`include "mclr_map.svh"

module mclr_log_bank #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_set,
    input wire logic i_wr,
    input wire logic [W-1:0] i_wdata,
    input wire logic i_rd_clr,
    input wire logic i_soft_rst,
    output logic [W-1:0] o_log
);

    ////////////////////////////////////////////////////////////////////////
    // one sticky flag per fault condition
    genvar k;
    generate
        for (k = 0; k < W; k++) begin : g_bit
            logic bit_ff;
            logic nxt_bit;
            // set wins over any clear so no event is lost
            always_comb begin
                nxt_bit = bit_ff;
                if (i_soft_rst) begin
                    nxt_bit = 1'h0;
                end else if (i_wr) begin
                    nxt_bit = i_wdata[k];
                end else if (i_rd_clr) begin
                    nxt_bit = 1'h0;
                end
                nxt_bit = nxt_bit | i_set[k];
            end
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    bit_ff <= 1'h0;
                end else begin
                    bit_ff <= nxt_bit;
                end
            end
            assign o_log[k] = bit_ff;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_log_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!i_wr && !i_rd_clr && !i_soft_rst)
            |=> ((o_log & $past(o_log)) == $past(o_log));
    endproperty
    a_log_sticky: assert property (p_log_sticky)
        else $error("fault log bit dropped without a clear");

    property p_log_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_set != '0) |=> ((o_log & $past(i_set)) == $past(i_set));
    endproperty
    a_log_set: assert property (p_log_set)
        else $error("fault event not recorded in log");

endmodule // mclr_log_bank

// [hdl/mclr_map.svh]
// Summary of operation
// - addressing clears alert when clear-enable set
// - control_b bits 6,2:1 read zero, unwritable
// - clear-on-read bit clears fault logs on read
// - stuck-bus timeout wakes shutdown when enabled
// - writing peak-hold bit resets min/max registers
// - writing reset bit restores all register defaults
// - enable bits 7:6 gate power alerts
// - enable bits 5:4 gate shunt-drop alerts
// - enable bits 3:2 gate supply-voltage alerts
// - enable bits 1:0 gate aux input alerts
// - log bits 7:6 record power over/under
// - log bits 5:4 record shunt-drop over/under
// - log bits 3:2 record supply over/under
// - log bits 1:0 record aux over/under
// - resolution bit: 1 is 8-bit, 0 12-bit
// - resolution bits 6:0 read zero, unwritable
//
`ifndef MCLR_MAP_SVH
`define MCLR_MAP_SVH

// register offsets
`define MCLR_OFS_CONTROL_B 8'h01
`define MCLR_OFS_IRQ_EN_CH1 8'h02
`define MCLR_OFS_LOG_CH1 8'h03
`define MCLR_OFS_ADC_RES 8'h04

// control_b field positions
`define MCLR_CB_ALERT_CLR 7
`define MCLR_CB_CLR_ON_RD 5
`define MCLR_CB_AUTO_WAKE 4
`define MCLR_CB_PEAK_RST 3
`define MCLR_CB_SOFT_RST 0

// writable masks, reserved bits stay zero
`define MCLR_CB_WMASK 8'hB8
`define MCLR_RES_WMASK 8'h80
`define MCLR_RES_BIT 7

// reset values
`define MCLR_CB_RESET 8'h00
`define MCLR_EN_RESET 8'h00
`define MCLR_LOG_RESET 8'h00
`define MCLR_RES_RESET 8'h00

`endif

// [hdl/mclr_pkg.sv]
package mclr_pkg;
    // converter width selection
    typedef enum logic [0:0] {
        MCLR_RES_12B = 1'h0,
        MCLR_RES_8B = 1'h1
    } mclr_res_e;
    typedef logic [7:0] mclr_byte_t;
endpackage

// [hdl/mclr_regs.sv]
`timescale 1ns/10ps
`include "mclr_map.svh"

module mclr_regs (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // register access from the serial engine
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    // bus and power state events
    input wire logic i_dev_addressed,
    input wire logic i_stuck_timeout,
    input wire logic i_in_shutdown,
    // channel-1 limit comparator events
    input wire logic i_pwr_over,
    input wire logic i_pwr_under,
    input wire logic i_shunt_over,
    input wire logic i_shunt_under,
    input wire logic i_volt_over,
    input wire logic i_volt_under,
    input wire logic i_aux_over,
    input wire logic i_aux_under,
    // outputs
    output logic [7:0] o_reg_rdata,
    output logic o_alert,
    output logic o_wake_req,
    output logic o_peak_reset,
    output logic o_reg_reset,
    output logic o_adc_8bit
);

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'h0;
            rst_sync_ff <= 1'h0;
        end else begin
            rst_meta_ff <= 1'h1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic wr_cb;
    logic wr_en;
    logic wr_log;
    logic wr_res;
    logic rd_log;
    logic soft_rst;

    assign wr_cb = i_reg_wr && (i_reg_addr == `MCLR_OFS_CONTROL_B);
    assign wr_en = i_reg_wr && (i_reg_addr == `MCLR_OFS_IRQ_EN_CH1);
    assign wr_log = i_reg_wr && (i_reg_addr == `MCLR_OFS_LOG_CH1);
    assign wr_res = i_reg_wr && (i_reg_addr == `MCLR_OFS_ADC_RES);
    assign rd_log = i_reg_rd && (i_reg_addr == `MCLR_OFS_LOG_CH1);

    // reset request wins over the rest of the written byte
    assign soft_rst = wr_cb && i_reg_wdata[`MCLR_CB_SOFT_RST];

    ////////////////////////////////////////////////////////////////////////
    // control_b, enable and resolution registers
    mclr_pkg::mclr_byte_t cb_ff;
    mclr_pkg::mclr_byte_t nxt_cb;
    mclr_pkg::mclr_byte_t en_ff;
    mclr_pkg::mclr_byte_t nxt_en;
    mclr_pkg::mclr_res_e res_ff;
    mclr_pkg::mclr_res_e nxt_res;

    // reserved bits are masked off, so they never hold a one
    always_comb begin
        nxt_cb = cb_ff;
        nxt_en = en_ff;
        nxt_res = res_ff;
        if (soft_rst) begin
            nxt_cb = `MCLR_CB_RESET;
            nxt_en = `MCLR_EN_RESET;
            nxt_res = mclr_pkg::mclr_res_e'(1'(`MCLR_RES_RESET >> `MCLR_RES_BIT));
        end else begin
            if (wr_cb) begin
                nxt_cb = i_reg_wdata & `MCLR_CB_WMASK;
            end
            if (wr_en) begin
                nxt_en = i_reg_wdata;
            end
            if (wr_res) begin
                nxt_res = mclr_pkg::mclr_res_e'(i_reg_wdata[`MCLR_RES_BIT]);
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cb_ff <= `MCLR_CB_RESET;
            en_ff <= `MCLR_EN_RESET;
            res_ff <= mclr_pkg::MCLR_RES_12B;
        end else begin
            cb_ff <= nxt_cb;
            en_ff <= nxt_en;
            res_ff <= nxt_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel-1 fault log
    logic [7:0] fault_set;
    logic [7:0] log_q;
    logic log_rd_clr;

    assign fault_set[7:6] = {i_pwr_over, i_pwr_under};
    assign fault_set[5:4] = {i_shunt_over, i_shunt_under};
    assign fault_set[3:2] = {i_volt_over, i_volt_under};
    assign fault_set[1:0] = {i_aux_over, i_aux_under};

    // read clears only while clear-on-read is enabled
    assign log_rd_clr = rd_log && cb_ff[`MCLR_CB_CLR_ON_RD];

    mclr_log_bank #(
        .W(8)
    ) u_log (
        .i_clk(i_mclk),
        .i_rst_n(rst_n),
        .i_set(fault_set),
        .i_wr(wr_log),
        .i_wdata(i_reg_wdata),
        .i_rd_clr(log_rd_clr),
        .i_soft_rst(soft_rst),
        .o_log(log_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // alert: latched on a newly enabled fault, released by addressing with clear-enable set or once no enabled fault is logged
    logic [7:0] pend_vec;
    logic [7:0] pend_prev_ff;
    logic [7:0] nxt_pend_prev;
    logic pend_rise;
    logic addr_clr;
    logic alert_ff;
    logic nxt_alert;

    assign pend_vec[7:6] = log_q[7:6] & en_ff[7:6];
    assign pend_vec[5:4] = log_q[5:4] & en_ff[5:4];
    assign pend_vec[3:2] = log_q[3:2] & en_ff[3:2];
    assign pend_vec[1:0] = log_q[1:0] & en_ff[1:0];

    assign pend_rise = |(pend_vec & ~pend_prev_ff);
    assign addr_clr = i_dev_addressed && cb_ff[`MCLR_CB_ALERT_CLR];

    // a fresh fault wins over a release in the same cycle
    always_comb begin
        nxt_pend_prev = pend_vec;
        nxt_alert = alert_ff;
        if (addr_clr || (pend_vec == 8'h00)) begin
            nxt_alert = 1'h0;
        end
        if (pend_rise) begin
            nxt_alert = 1'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_prev_ff <= 8'h00;
            alert_ff <= 1'h0;
        end else begin
            pend_prev_ff <= nxt_pend_prev;
            alert_ff <= nxt_alert;
        end
    end

    assign o_alert = alert_ff;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle action pulses towards the rest of the device
    logic wake_ff;
    logic nxt_wake;
    logic peak_ff;
    logic nxt_peak;
    logic rrst_ff;
    logic nxt_rrst;

    // peak reset is suppressed when the same byte asks for a full reset
    always_comb begin
        nxt_wake = i_stuck_timeout && i_in_shutdown
            && cb_ff[`MCLR_CB_AUTO_WAKE];
        nxt_peak = wr_cb && !soft_rst
            && i_reg_wdata[`MCLR_CB_PEAK_RST];
        nxt_rrst = soft_rst;
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_ff <= 1'h0;
            peak_ff <= 1'h0;
            rrst_ff <= 1'h0;
        end else begin
            wake_ff <= nxt_wake;
            peak_ff <= nxt_peak;
            rrst_ff <= nxt_rrst;
        end
    end

    assign o_wake_req = wake_ff;
    assign o_peak_reset = peak_ff;
    assign o_reg_reset = rrst_ff;
    assign o_adc_8bit = (res_ff == mclr_pkg::MCLR_RES_8B);

    ////////////////////////////////////////////////////////////////////////
    // read data, held until the next read
    mclr_pkg::mclr_byte_t rdata_ff;
    mclr_pkg::mclr_byte_t nxt_rdata;

    // unmapped offsets answer zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (i_reg_rd) begin
            case (i_reg_addr)
                `MCLR_OFS_CONTROL_B: nxt_rdata = cb_ff & `MCLR_CB_WMASK;
                `MCLR_OFS_IRQ_EN_CH1: nxt_rdata = en_ff;
                `MCLR_OFS_LOG_CH1: nxt_rdata = log_q;
                `MCLR_OFS_ADC_RES: nxt_rdata = {res_ff, 7'h00};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_alert_addr_clr;
        @(posedge i_mclk) disable iff (!rst_n)
        (alert_ff && addr_clr && !pend_rise) |=> !o_alert;
    endproperty
    a_alert_addr_clr: assert property (p_alert_addr_clr)
        else $error("alert not released on addressing");

    property p_alert_addr_keep;
        @(posedge i_mclk) disable iff (!rst_n)
        (alert_ff && i_dev_addressed && !cb_ff[`MCLR_CB_ALERT_CLR]
            && (pend_vec != 8'h00)) |=> o_alert;
    endproperty
    a_alert_addr_keep: assert property (p_alert_addr_keep)
        else $error("alert released with clear-enable off");

    property p_cb_rsvd;
        @(posedge i_mclk) disable iff (!rst_n)
        (i_reg_rd && (i_reg_addr == `MCLR_OFS_CONTROL_B))
            |=> ((o_reg_rdata & ~`MCLR_CB_WMASK) == 8'h00);
    endproperty
    a_cb_rsvd: assert property (p_cb_rsvd)
        else $error("reserved control bits read nonzero");

    property p_cor_clear;
        @(posedge i_mclk) disable iff (!rst_n)
        (rd_log && cb_ff[`MCLR_CB_CLR_ON_RD] && !i_reg_wr
            && (fault_set == 8'h00)) |=> (log_q == 8'h00);
    endproperty
    a_cor_clear: assert property (p_cor_clear)
        else $error("fault log not cleared on read");

    property p_cor_keep;
        @(posedge i_mclk) disable iff (!rst_n)
        (rd_log && !cb_ff[`MCLR_CB_CLR_ON_RD] && !i_reg_wr)
            |=> (log_q == ($past(log_q) | $past(fault_set)));
    endproperty
    a_cor_keep: assert property (p_cor_keep)
        else $error("fault log changed by plain read");

    property p_wake;
        @(posedge i_mclk) disable iff (!rst_n)
        (i_stuck_timeout && i_in_shutdown)
            |=> (o_wake_req == $past(cb_ff[`MCLR_CB_AUTO_WAKE]));
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake request does not follow auto-wake bit");

    property p_peak;
        @(posedge i_mclk) disable iff (!rst_n)
        (wr_cb && i_reg_wdata[`MCLR_CB_PEAK_RST] && !soft_rst)
            |=> o_peak_reset ##1 (o_peak_reset == $past(nxt_peak));
    endproperty
    a_peak: assert property (p_peak)
        else $error("peak hold reset not pulsed");

    property p_soft_rst;
        @(posedge i_mclk) disable iff (!rst_n)
        soft_rst |=> (o_reg_reset && (cb_ff == `MCLR_CB_RESET)
            && (en_ff == `MCLR_EN_RESET) && !o_adc_8bit
            && ((log_q & ~$past(fault_set)) == 8'h00));
    endproperty
    a_soft_rst: assert property (p_soft_rst)
        else $error("register reset did not restore defaults");

    property p_res_write;
        @(posedge i_mclk) disable iff (!rst_n)
        (wr_res && !soft_rst) |=> (o_adc_8bit == $past(i_reg_wdata[7]));
    endproperty
    a_res_write: assert property (p_res_write)
        else $error("resolution output does not match write");

    property p_res_rsvd;
        @(posedge i_mclk) disable iff (!rst_n)
        (i_reg_rd && (i_reg_addr == `MCLR_OFS_ADC_RES))
            |=> ((o_reg_rdata[6:0] == 7'h00) && (o_reg_rdata[7] == $past(o_adc_8bit)));
    endproperty
    a_res_rsvd: assert property (p_res_rsvd)
        else $error("resolution reserved bits read nonzero");

    property p_alert_set;
        @(posedge i_mclk) disable iff (!rst_n)
        pend_rise |=> o_alert;
    endproperty
    a_alert_set: assert property (p_alert_set)
        else $error("alert missing for enabled fault");

    property p_alert_cause;
        @(posedge i_mclk) disable iff (!rst_n)
        (pend_vec == 8'h00) |=> !o_alert;
    endproperty
    a_alert_cause: assert property (p_alert_cause)
        else $error("alert without enabled fault");

    property p_enable_gate;
        @(posedge i_mclk) disable iff (!rst_n)
        ((fault_set & ~en_ff) != 8'h00) && (pend_vec == 8'h00) && !wr_en
            |=> !o_alert;
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("disabled fault raised the alert");

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    c_addr_release: cover property (@(posedge i_mclk) disable iff (!rst_n)
        alert_ff && addr_clr ##1 !o_alert);
    c_cor_read: cover property (@(posedge i_mclk) disable iff (!rst_n)
        log_rd_clr && (log_q != 8'h00));
    c_soft_reset: cover property (@(posedge i_mclk) disable iff (!rst_n)
        soft_rst ##1 o_reg_reset);
    c_wake: cover property (@(posedge i_mclk) disable iff (!rst_n)
        o_wake_req);

endmodule // mclr_regs

// [test/mclr_host_model.sv]
`timescale 1ns/10ps

module mclr_host_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd,
    output logic o_addressed
);
    // idle bus, nothing requested
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
        o_addressed = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // one-byte write; released lines are scrambled so stale values never help
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    // one-byte read; data is registered at the strobe edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_mclk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
    endtask

    // the part sees its own bus address
    task automatic hit();
        @(negedge i_mclk);
        o_addressed = 1'b1;
        @(negedge i_mclk);
        o_addressed = 1'b0;
    endtask
endmodule // mclr_host_model

// [test/tb_monitor_control_limit_regs.sv]
`timescale 1ns/10ps

module tb_monitor_control_limit_regs;
    logic i_mclk;
    logic i_rst_n;
    logic [7:0] fault_v;
    logic stuck;
    logic shutdown;
    logic [7:0] addr, wdata, rdata, rv, en;
    logic wr, rd, addressed, alert, wake, peak, reg_rst, adc8;
    int failures, checks, cycles, peak_cnt, rst_cnt, wake_cnt, exp_peak, exp_wake;

    mclr_regs mclr_regs_i (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .i_dev_addressed(addressed), .i_stuck_timeout(stuck), .i_in_shutdown(shutdown),
        .i_pwr_over(fault_v[7]), .i_pwr_under(fault_v[6]),
        .i_shunt_over(fault_v[5]), .i_shunt_under(fault_v[4]),
        .i_volt_over(fault_v[3]), .i_volt_under(fault_v[2]),
        .i_aux_over(fault_v[1]), .i_aux_under(fault_v[0]),
        .o_reg_rdata(rdata), .o_alert(alert), .o_wake_req(wake),
        .o_peak_reset(peak), .o_reg_reset(reg_rst), .o_adc_8bit(adc8)
    );

    mclr_host_model mclr_host_model_i (
        .i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_wdata(wdata), .o_rd(rd), .o_addressed(addressed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the ceiling is far above the few hundred cycles used
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    // pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge i_mclk) begin
        cycles++;
        peak_cnt += int'(peak === 1'b1);
        rst_cnt += int'(reg_rst === 1'b1);
        wake_cnt += int'(wake === 1'b1);
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare tasks and expectations
    function automatic logic [7:0] f_cb(input logic [7:0] d);
        return {d[7], 1'b0, d[5:3], 3'h0};
    endfunction

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_cnt(input string n, input int e, input int g);
        checks++;
        if (g != e) begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        mclr_host_model_i.read(a, d);
        chk_byte(n, e, d);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    // comparator events as one-cycle pulses
    task automatic pulse_fault(input logic [7:0] v);
        @(negedge i_mclk);
        fault_v = v;
        @(negedge i_mclk);
        fault_v = 8'h00;
    endtask

    task automatic test_done();
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {failures, checks, cycles, peak_cnt, rst_cnt, wake_cnt, exp_peak, exp_wake} = '0;
        fault_v = 8'h00;
        stuck = 1'b0;
        shutdown = 1'b0;
        i_rst_n = 1'b0;
        void'($urandom(32'h41FE3A64));
        tick(10);
        i_rst_n = 1'b1;
        tick(3);
        // defaults, plus unmapped places
        for (int a = 0; a < 6; a++) rd_chk("reset_val", 8'(a), 8'h00);
        rd_chk("unmapped", 8'h05 + 8'($urandom_range(0, 200)), 8'h00);
        // register access, all-ones corner first for control_b (reset bit held low) and adc_res
        for (int i = 0; i < 8; i++) begin
            rv = (i == 0) ? 8'hFE : 8'($urandom) & 8'hFE;
            mclr_host_model_i.write(8'h01, rv);
            exp_peak += int'(rv[3]);
            rd_chk("control_b", 8'h01, f_cb(rv));
            rv = (i == 0) ? 8'hFF : 8'($urandom);
            mclr_host_model_i.write(8'h04, rv);
            rd_chk("adc_res", 8'h04, {rv[7], 7'h00});
            chk_bit("adc_8bit", rv[7], adc8);
            rv = 8'($urandom);
            mclr_host_model_i.write(8'h02, rv);
            rd_chk("irq_en", 8'h02, rv);
        end
        tick(2);
        chk_cnt("peak_pulses", exp_peak, peak_cnt);
        mclr_host_model_i.write(8'h01, 8'h00);
        // each event source, gated by enables: none first, all last, random between
        for (int k = 0; k < 8; k++) begin
            en = (k == 0) ? 8'h00 : (k == 7) ? 8'hFF : 8'($urandom);
            mclr_host_model_i.write(8'h02, en);
            rv = (8'h01 << k) | ((k > 3) ? 8'($urandom) : 8'h00);
            pulse_fault(rv);
            tick(3);
            chk_bit("alert", |(rv & en), alert);
            rd_chk("log_ch1", 8'h03, rv);
            rd_chk("log_sticky", 8'h03, rv);
            mclr_host_model_i.write(8'h03, 8'h00);
            tick(2);
            chk_bit("alert_off", 1'b0, alert);
            rd_chk("log_cleared", 8'h03, 8'h00);
        end
        // addressing releases the alert only when enabled
        mclr_host_model_i.write(8'h02, 8'hFF);
        pulse_fault(8'h80);
        tick(3);
        chk_bit("alert_set", 1'b1, alert);
        mclr_host_model_i.hit();
        tick(2);
        chk_bit("alert_kept", 1'b1, alert);
        mclr_host_model_i.write(8'h01, 8'h80);
        mclr_host_model_i.hit();
        tick(4);
        chk_bit("alert_released", 1'b0, alert);
        // clear on read: first read returns, second sees empty log
        mclr_host_model_i.write(8'h01, 8'h20);
        rd_chk("cor_first", 8'h03, 8'h80);
        rd_chk("cor_second", 8'h03, 8'h00);
        // wake only with bit set and part in shutdown
        for (int m = 0; m < 3; m++) begin
            mclr_host_model_i.write(8'h01, (m == 0) ? 8'h00 : 8'h10);
            @(negedge i_mclk);
            shutdown = (m != 2);
            stuck = 1'b1;
            @(negedge i_mclk);
            stuck = 1'b0;
            tick(3);
            exp_wake += int'(m == 1);
            chk_cnt("wake_pulses", exp_wake, wake_cnt);
        end
        // soft reset wins over peak reset in the same byte
        mclr_host_model_i.write(8'h04, 8'h80);
        mclr_host_model_i.write(8'h01, 8'h38);
        exp_peak++;
        pulse_fault(8'h0F);
        mclr_host_model_i.write(8'h01, 8'h09);
        tick(3);
        chk_cnt("reg_reset_pulses", 1, rst_cnt);
        chk_cnt("peak_pulses_end", exp_peak, peak_cnt);
        for (int a = 1; a < 5; a++) rd_chk("after_reset", 8'(a), 8'h00);
        chk_bit("adc_after_reset", 1'b0, adc8);
        chk_bit("alert_after_reset", 1'b0, alert);
        test_done();
    end
endmodule // tb_monitor_control_limit_regs
